// ===== logic/cdtc_pkg.sv
// package: register map, fields, reset values and timing constants
package cdtc_pkg;
    localparam logic [7:0] PERF_OFS  = 8'h40;
    localparam logic [7:0] CFG1_OFS  = 8'h41;
    localparam logic [7:0] CFG2_OFS  = 8'h42;
    localparam logic [7:0] L1DB_OFS  = 8'h43;
    localparam logic [7:0] DTC1_OFS  = 8'h44;
    localparam logic [7:0] PERF_RST  = 8'h00;
    localparam logic [7:0] CFG2_RST  = 8'h00;
    localparam logic [7:0] L1DB_RST  = 8'h00;
    localparam logic [7:0] DTC1_RST  = 8'h00;
    // writable bit masks, reserved bits read zero
    localparam logic [7:0] PERF_MASK = 8'hF1;
    localparam logic [7:0] CFG1_MASK = 8'hDF;
    localparam logic [7:0] CFG2_MASK = 8'hF7;
    localparam logic [7:0] L1DB_MASK = 8'hFF;
    localparam logic [7:0] DTC1_MASK = 8'hFF;
    localparam logic [1:0] CFG1_MUST = 2'h2;
    // field positions
    localparam int TAGX_LSB = 6;
    localparam int FASTNA_BIT = 5;
    localparam int SNOOP_BIT = 4;
    localparam int CHKPT_BIT = 0;
    localparam int BANK_BIT = 7;
    localparam int TYPE_BIT = 6;
    localparam int MTEST_BIT = 4;
    localparam int SIZE_LSB = 1;
    localparam int TAGDLY_BIT = 7;
    localparam int SRALLOC_BIT = 6;
    localparam int ABCACHE_BIT = 5;
    localparam int CLEAN_BIT = 4;
    localparam int MISS_BIT = 2;
    localparam int DIRTY_BIT = 1;
    localparam int L2ON_BIT = 0;
    localparam int ROW_LSB = 2;
    localparam int RAW_BIT = 1;
    localparam int L1ON_BIT = 0;
    localparam int EDOT_LSB = 6;
    localparam int EDOEN_BIT = 5;
    localparam int EDORD_BIT = 4;
    localparam int RCD_BIT = 3;
    localparam int PRE_BIT = 2;
    localparam int PMRD_BIT = 1;
    localparam int WR_BIT = 0;
    // timing counts in cpu clocks
    localparam logic [3:0] SLOW_T = 4'h3;
    localparam logic [3:0] FAST_T = 4'h2;
    localparam logic [3:0] PRE_SLOW = 4'h4;
    localparam logic [3:0] PRE_FAST = 4'h3;
    localparam logic [3:0] REF_SLOW = 4'h5;
    localparam logic [3:0] REF_FAST = 4'h4;
    localparam logic [3:0] PM_SLOW = 4'h4;
    localparam logic [10:0] EDO_BASE = 11'h080;
    // cache size codes and tag width codes
    localparam logic [1:0] SIZE_NONE = 2'h0;
    localparam logic [4:0] LIMIT_64M_LOG2 = 5'h1A;
    localparam int STRAP_BANK = 24;
    localparam int STRAP_TYPE = 23;
    localparam int STRAP_SIZE = 21;
    typedef enum logic [1:0] {
        CDTC_WR   = 2'b01,
        CDTC_RD   = 2'b10,
        CDTC_NONE = 2'b00
    } cdtc_cmd_type;
endpackage : cdtc_pkg

// ===== logic/cdtc_cfg_if.sv
// interface: configuration cycle port between host side and device
`timescale 1ns/1ns
interface cdtc_cfg_if;
    logic       cfgValid;
    logic       cfgWrite;
    logic [7:0] cfgIndex;
    logic [3:0] cfgByteEn;
    logic [31:0] cfgWdata;
    logic       cfgDone;
    logic [31:0] cfgRdata;
    modport dev  (input cfgValid, cfgWrite, cfgIndex, cfgByteEn, cfgWdata,
                  output cfgDone, cfgRdata);
    modport host (output cfgValid, cfgWrite, cfgIndex, cfgByteEn, cfgWdata,
                  input cfgDone, cfgRdata);
endinterface : cdtc_cfg_if

// ===== logic/cdtc_timing_calc.sv
// timing decode: turns dram timing bits into clock counts
`timescale 1ns/1ns
module cdtc_timing_calc
    import cdtc_pkg::*;
(
    input  wire logic [7:0]  dtc,
    output logic [3:0]       rasToCas,
    output logic [3:0]       precharge,
    output logic [3:0]       refreshRas,
    output logic [3:0]       edoReadBeat,
    output logic [3:0]       pageReadBeat,
    output logic [3:0]       writeBeat,
    output logic [10:0]      edoTimer
);
    function automatic logic [3:0] pick(input logic fast, input logic [3:0] slow);
        pick = fast ? 4'(slow - 4'h1) : slow;
    endfunction : pick
    always_comb begin
        rasToCas     = pick(dtc[RCD_BIT], SLOW_T);
        precharge    = pick(dtc[PRE_BIT], PRE_SLOW);
        refreshRas   = pick(dtc[PRE_BIT], REF_SLOW);
        edoReadBeat  = pick(dtc[EDORD_BIT], SLOW_T);
        pageReadBeat = pick(dtc[PMRD_BIT], PM_SLOW);
        writeBeat    = pick(dtc[WR_BIT], SLOW_T);
        edoTimer     = EDO_BASE << dtc[EDOT_LSB +: 2];
    end
endmodule : cdtc_timing_calc

// ===== logic/cdtc_device.sv
// device end: tuning registers and the controls they steer
//
// Design decision made in cdtc_host: the AXI4-Lite slave port.
`timescale 1ns/1ns
module cdtc_device
    import cdtc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    cdtc_cfg_if.dev          cfg,
    input  wire logic [24:21] hostAddressStrap,
    input  wire logic        abRegionLocal,
    input  wire logic        cacheableCycle,
    input  wire logic        tagHit,
    input  wire logic        tagDirty,
    output logic             extraTagBitOutput,
    output logic [1:0]       rowStrobeAsTag,
    output logic             fastNextAddress,
    output logic [1:0]       snoopSampleClock,
    output logic [1:0]       hitCheckClock,
    output logic [1:0]       cacheBanks,
    output logic             pipelinedSram,
    output logic             coherenceTestMode,
    output logic [1:0]       cacheSize,
    output logic [4:0]       cacheableLimitLog2,
    output logic             tagHoldHalfClock,
    output logic             singleReadAllocate,
    output logic             abRegionCacheable,
    output logic             lookupHit,
    output logic             lookupDirty,
    output logic             l2Enable,
    output logic [5:0]       rowHalfWidth,
    output logic             readAroundWrite,
    output logic             cacheAllowN,
    output logic             edoDetectEnable,
    output logic [10:0]      edoTimerClocks,
    output logic [3:0]       rasToCasClocks,
    output logic [3:0]       prechargeClocks,
    output logic [3:0]       refreshRasClocks,
    output logic [3:0]       edoReadClocks,
    output logic [3:0]       pageReadClocks,
    output logic [3:0]       writeClocks
);
    typedef struct packed {
        logic [7:0]  perf;
        logic [7:0]  cfg1;
        logic [7:0]  cfg2;
        logic [7:0]  l1db;
        logic [7:0]  dtc1;
        logic        strapDone;
        logic        done;
        logic [31:0] rdata;
        logic        allowN;
        logic        hit;
        logic        dirty;
        logic [3:0]  r2c;
        logic [3:0]  pre;
        logic [3:0]  refr;
        logic [3:0]  edoRd;
        logic [3:0]  pmRd;
        logic [3:0]  wr;
        logic [10:0] edoT;
        logic        extraTag;
        logic [1:0]  rowTag;
        logic [1:0]  snoop;
        logic [1:0]  hitChk;
        logic [1:0]  banks;
        logic [4:0]  limit;
        logic        abc;
    } cdtc_dev_type;

    cdtc_dev_type s_q;
    cdtc_dev_type s_d;
    logic [3:0]  tR2c;
    logic [3:0]  tPre;
    logic [3:0]  tRef;
    logic [3:0]  tEdo;
    logic [3:0]  tPm;
    logic [3:0]  tWr;
    logic [10:0] tEdoT;

    cdtc_timing_calc uTiming (
        .dtc          (s_q.dtc1),
        .rasToCas     (tR2c),
        .precharge    (tPre),
        .refreshRas   (tRef),
        .edoReadBeat  (tEdo),
        .pageReadBeat (tPm),
        .writeBeat    (tWr),
        .edoTimer     (tEdoT)
    );

    // byte lane of a word aligned at 40h; 44h sits in the next word
    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nv,
                                         input logic [7:0] mask);
        merge = (nv & mask) | (old & ~mask);
    endfunction : merge

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        // straps caught once, the clock after reset release
        if (!s_q.strapDone) begin
            s_d.strapDone = 1'b1;
            s_d.cfg1[BANK_BIT] = hostAddressStrap[STRAP_BANK];
            s_d.cfg1[TYPE_BIT] = hostAddressStrap[STRAP_TYPE];
            s_d.cfg1[SIZE_LSB +: 2] = hostAddressStrap[STRAP_SIZE +: 2];
            s_d.cfg1[3] = CFG1_MUST[1];
            s_d.cfg1[0] = CFG1_MUST[0];
        end else if (cfg.cfgValid && !s_q.done) begin
            s_d.done = 1'b1;
            s_d.rdata = 32'h0000_0000;
            if (cfg.cfgIndex[7:2] == PERF_OFS[7:2]) begin
                if (cfg.cfgWrite) begin
                    if (cfg.cfgByteEn[0])
                        s_d.perf = merge(s_q.perf, cfg.cfgWdata[7:0], PERF_MASK);
                    if (cfg.cfgByteEn[1])
                        s_d.cfg1 = merge(s_q.cfg1, cfg.cfgWdata[15:8], CFG1_MASK);
                    if (cfg.cfgByteEn[2])
                        s_d.cfg2 = merge(s_q.cfg2, cfg.cfgWdata[23:16], CFG2_MASK);
                    if (cfg.cfgByteEn[3])
                        s_d.l1db = merge(s_q.l1db, cfg.cfgWdata[31:24], L1DB_MASK);
                end else begin
                    s_d.rdata = {s_q.l1db, s_q.cfg2, s_q.cfg1, s_q.perf};
                end
            end else if (cfg.cfgIndex[7:2] == DTC1_OFS[7:2]) begin
                if (cfg.cfgWrite) begin
                    if (cfg.cfgByteEn[0]) s_d.dtc1 = merge(s_q.dtc1, cfg.cfgWdata[7:0], DTC1_MASK);
                end else begin
                    s_d.rdata = {24'h00_0000, s_q.dtc1};
                end
            end
        end
        // lookup overrides: miss forces no hit; for dirty, clean wins over dirty
        s_d.hit = tagHit && !s_q.cfg2[MISS_BIT] && s_q.cfg2[L2ON_BIT]
                  && s_q.cfg1[SIZE_LSB +: 2] != SIZE_NONE;
        s_d.dirty = s_q.cfg2[CLEAN_BIT] ? 1'b0 :
                    (s_q.cfg2[DIRTY_BIT] ? 1'b1 : tagDirty);
        s_d.allowN = !(s_q.l1db[L1ON_BIT] && cacheableCycle);
        // decodes registered so every pin leaves a flip-flop, one clock late
        s_d.extraTag = s_q.perf[TAGX_LSB +: 2] != 2'h0;
        s_d.rowTag = {s_q.perf[TAGX_LSB +: 2] == 2'h3, s_q.perf[TAGX_LSB + 1]};
        s_d.snoop = s_q.perf[SNOOP_BIT] ? 2'h2 : 2'h3;
        s_d.hitChk = s_q.perf[CHKPT_BIT] ? 2'h2 : 2'h3;
        s_d.banks = s_q.cfg1[BANK_BIT] ? 2'h1 : 2'h2;
        // tag width 8..11 bits gives 64M..512M
        s_d.limit = 5'(LIMIT_64M_LOG2 + 5'(s_q.perf[TAGX_LSB +: 2]));
        s_d.abc = s_q.cfg2[ABCACHE_BIT] && abRegionLocal;
        s_d.r2c = tR2c;
        s_d.pre = tPre;
        s_d.refr = tRef;
        s_d.edoRd = tEdo;
        s_d.pmRd = tPm;
        s_d.wr = tWr;
        s_d.edoT = tEdoT;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.perf <= PERF_RST;
            s_q.cfg2 <= CFG2_RST;
            s_q.l1db <= L1DB_RST;
            s_q.dtc1 <= DTC1_RST;
            s_q.allowN <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign cfg.cfgDone  = s_q.done;
    assign cfg.cfgRdata = s_q.rdata;

    assign extraTagBitOutput  = s_q.extraTag;
    assign rowStrobeAsTag     = s_q.rowTag;
    assign fastNextAddress    = s_q.perf[FASTNA_BIT];
    assign snoopSampleClock   = s_q.snoop;
    assign hitCheckClock      = s_q.hitChk;
    assign cacheBanks         = s_q.banks;
    assign pipelinedSram      = s_q.cfg1[TYPE_BIT];
    assign coherenceTestMode  = s_q.cfg1[MTEST_BIT];
    assign cacheSize          = s_q.cfg1[SIZE_LSB +: 2];
    assign cacheableLimitLog2 = s_q.limit;
    assign tagHoldHalfClock   = s_q.cfg2[TAGDLY_BIT];
    assign singleReadAllocate = s_q.cfg2[SRALLOC_BIT];
    assign abRegionCacheable  = s_q.abc;
    assign lookupHit          = s_q.hit;
    assign lookupDirty        = s_q.dirty;
    assign l2Enable           = s_q.cfg2[L2ON_BIT];
    assign rowHalfWidth       = s_q.l1db[ROW_LSB +: 6];
    assign readAroundWrite    = s_q.l1db[RAW_BIT];
    assign cacheAllowN        = s_q.allowN;
    assign edoDetectEnable    = s_q.dtc1[EDOEN_BIT];
    assign edoTimerClocks     = s_q.edoT;
    assign rasToCasClocks     = s_q.r2c;
    assign prechargeClocks    = s_q.pre;
    assign refreshRasClocks   = s_q.refr;
    assign edoReadClocks      = s_q.edoRd;
    assign pageReadClocks     = s_q.pmRd;
    assign writeClocks        = s_q.wr;
endmodule : cdtc_device

// ===== logic/cdtc_host.sv
// host end: AXI4-Lite slave turning software orders into config cycles
`timescale 1ns/1ns
module cdtc_host
    import cdtc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    cdtc_cfg_if.host         cfg,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_CYC  = 3'b001,
        H_BRSP = 3'b010,
        H_RRSP = 3'b011
    } cdtc_hst_type;
    typedef struct packed {
        cdtc_hst_type st;
        logic        awHave;
        logic        wHave;
        logic [7:0]  addr;
        logic [31:0] data;
        logic [3:0]  strb;
        logic        valid;
        logic        write;
        logic        awr;
        logic        wr;
        logic        arr;
        logic        bv;
        logic        rv;
        logic [31:0] rd;
    } cdtc_host_type;
    cdtc_host_type s_q;
    cdtc_host_type s_d;

    always_comb begin
        s_d = s_q;
        s_d.awr = 1'b0;
        s_d.wr = 1'b0;
        s_d.arr = 1'b0;
        case (s_q.st)
            H_IDLE: begin
                if (s_axi_awvalid && !s_q.awHave && !s_q.awr) begin
                    s_d.awr = 1'b1;
                    s_d.awHave = 1'b1;
                    s_d.addr = s_axi_awaddr;
                end
                if (s_axi_wvalid && !s_q.wHave && !s_q.wr) begin
                    s_d.wr = 1'b1;
                    s_d.wHave = 1'b1;
                    s_d.data = s_axi_wdata;
                    s_d.strb = s_axi_wstrb;
                end
                if (s_q.awHave && s_q.wHave) begin
                    s_d.st = H_CYC;
                    s_d.valid = 1'b1;
                    s_d.write = 1'b1;
                end else if (!s_q.awHave && !s_q.wHave && s_axi_arvalid
                             && !s_axi_awvalid && !s_axi_wvalid && !s_q.arr) begin
                    s_d.arr = 1'b1;
                    s_d.addr = s_axi_araddr;
                    s_d.strb = 4'hF;
                    s_d.st = H_CYC;
                    s_d.valid = 1'b1;
                    s_d.write = 1'b0;
                end
            end
            H_CYC: begin
                if (cfg.cfgDone) begin
                    s_d.valid = 1'b0;
                    s_d.rd = cfg.cfgRdata;
                    s_d.st = s_q.write ? H_BRSP : H_RRSP;
                    s_d.bv = s_q.write;
                    s_d.rv = !s_q.write;
                end
            end
            H_BRSP: begin
                if (s_axi_bready) begin
                    s_d.bv = 1'b0;
                    s_d.awHave = 1'b0;
                    s_d.wHave = 1'b0;
                    s_d.st = H_IDLE;
                end
            end
            H_RRSP: begin
                if (s_axi_rready) begin
                    s_d.rv = 1'b0;
                    s_d.st = H_IDLE;
                end
            end
            default: s_d.st = H_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.st <= H_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // config cycles stay word wide; lanes pick the bytes
    assign cfg.cfgValid   = s_q.valid;
    assign cfg.cfgWrite   = s_q.write;
    assign cfg.cfgIndex   = {s_q.addr[7:2], 2'b00};
    assign cfg.cfgByteEn  = s_q.strb;
    assign cfg.cfgWdata   = s_q.data;
    assign s_axi_awready  = s_q.awr;
    assign s_axi_wready   = s_q.wr;
    assign s_axi_arready  = s_q.arr;
    assign s_axi_bvalid   = s_q.bv;
    assign s_axi_bresp    = 2'b00;
    assign s_axi_rvalid   = s_q.rv;
    assign s_axi_rresp    = 2'b00;
    assign s_axi_rdata    = s_q.rd;
endmodule : cdtc_host

// ===== test/cdtc_assertions.sv
// checker: config link handshake and read-back rules
`timescale 1ns/1ns
module cdtc_assertions
    import cdtc_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic        cfgValid,
    input wire logic        cfgWrite,
    input wire logic [7:0]  cfgIndex,
    input wire logic [3:0]  cfgByteEn,
    input wire logic [31:0] cfgWdata,
    input wire logic        cfgDone,
    input wire logic [31:0] cfgRdata
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    AST_DONE_PULSE: assert property (cfgDone |=> !cfgDone)
        else $error("cfgDone longer than one cycle");
    AST_DONE_CAUSE: assert property (cfgDone |-> cfgValid)
        else $error("cfgDone without a request");
    AST_ANSWER_NEXT: assert property (cfgValid && !cfgDone |=> cfgDone)
        else $error("request not answered at next edge");
    AST_REQ_HOLD: assert property (cfgValid && !cfgDone |=>
        cfgValid && $stable(cfgIndex) && $stable(cfgWrite) && $stable(cfgWdata))
        else $error("request changed before answer");
    AST_WR_RDATA_ZERO: assert property (cfgDone && cfgWrite |-> cfgRdata == 32'h0)
        else $error("write answer carries data");
    AST_RSVD_WORD0: assert property (cfgDone && !cfgWrite && cfgIndex == PERF_OFS |->
        (cfgRdata & ~{L1DB_MASK, CFG2_MASK, CFG1_MASK, PERF_MASK}) == 32'h0)
        else $error("reserved bit read as one");
    AST_RSVD_WORD1: assert property (cfgDone && !cfgWrite && cfgIndex == DTC1_OFS |->
        cfgRdata[31:8] == 24'h0)
        else $error("unused lanes of timing word not zero");
    AST_UNMAPPED: assert property (cfgDone && !cfgWrite && cfgIndex != PERF_OFS
        && cfgIndex != DTC1_OFS |-> cfgRdata == 32'h0)
        else $error("unmapped word read not zero");
endmodule : cdtc_assertions

// ===== test/tb_top.sv
// testbench: both ends joined, axi-lite stimulus, register and output model
`timescale 1ns/1ns
module tb_top
    import cdtc_pkg::*;
;
    logic        ref_clk, rstn, abRegionLocal, cacheableCycle, tagHit, tagDirty;
    logic [24:21] hostAddressStrap;
    logic        extraTagBitOutput, fastNextAddress, pipelinedSram, coherenceTestMode;
    logic        tagHoldHalfClock, singleReadAllocate, abRegionCacheable, lookupHit;
    logic        lookupDirty, l2Enable, readAroundWrite, cacheAllowN, edoDetectEnable;
    logic [1:0]  rowStrobeAsTag, snoopSampleClock, hitCheckClock, cacheBanks, cacheSize;
    logic [4:0]  cacheableLimitLog2;
    logic [5:0]  rowHalfWidth;
    logic [10:0] edoTimerClocks;
    logic [3:0]  rasToCasClocks, prechargeClocks, refreshRasClocks;
    logic [3:0]  edoReadClocks, pageReadClocks, writeClocks;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed, rd, d;
    logic [3:0]  s_axi_wstrb, s;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]  mdl [5];
    logic [7:0]  msk [5];
    logic [7:0]  a;
    int          n_fail, n_compared;

    cdtc_cfg_if cdtc_cfg_if_i();
    cdtc_device cdtc_device_i(.ref_clk, .rstn, .cfg(cdtc_cfg_if_i), .hostAddressStrap,
        .abRegionLocal, .cacheableCycle, .tagHit, .tagDirty, .extraTagBitOutput,
        .rowStrobeAsTag, .fastNextAddress, .snoopSampleClock, .hitCheckClock, .cacheBanks,
        .pipelinedSram, .coherenceTestMode, .cacheSize, .cacheableLimitLog2,
        .tagHoldHalfClock, .singleReadAllocate, .abRegionCacheable, .lookupHit,
        .lookupDirty, .l2Enable, .rowHalfWidth, .readAroundWrite, .cacheAllowN,
        .edoDetectEnable, .edoTimerClocks, .rasToCasClocks, .prechargeClocks,
        .refreshRasClocks, .edoReadClocks, .pageReadClocks, .writeClocks);
    cdtc_host cdtc_host_i(.ref_clk, .rstn, .cfg(cdtc_cfg_if_i), .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    cdtc_assertions cdtc_assertions_i(.ref_clk, .rstn,
        .cfgValid(cdtc_cfg_if_i.cfgValid), .cfgWrite(cdtc_cfg_if_i.cfgWrite),
        .cfgIndex(cdtc_cfg_if_i.cfgIndex), .cfgByteEn(cdtc_cfg_if_i.cfgByteEn),
        .cfgWdata(cdtc_cfg_if_i.cfgWdata), .cfgDone(cdtc_cfg_if_i.cfgDone),
        .cfgRdata(cdtc_cfg_if_i.cfgRdata));

    always #5 ref_clk = ~ref_clk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic final_report();
        if (n_fail == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    // starts after an edge so no signal is driven twice in one step
    task automatic axiWrite(input logic [7:0] wa, input logic [31:0] wd, input logic [3:0] ws);
        @(posedge ref_clk);
        s_axi_awaddr <= wa;
        s_axi_wdata <= wd;
        s_axi_wstrb <= ws;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, 2'b00);
    endtask : axiWrite

    task automatic axiRead(input logic [7:0] ra, output logic [31:0] rdat);
        @(posedge ref_clk);
        s_axi_araddr <= ra;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rdat = s_axi_rdata;
        s_axi_rready <= 1'b0;
        chk(s_axi_rresp, 2'b00);
    endtask : axiRead

    function automatic logic [31:0] word(input logic [7:0] wa);
        if (wa == PERF_OFS) return {mdl[3], mdl[2], mdl[1], mdl[0]};
        return (wa == DTC1_OFS) ? {24'h0, mdl[4]} : 32'h0;
    endfunction : word

    // reserved bits never stored, so a lane write replaces the whole byte
    task automatic mdlWrite(input logic [7:0] wa, input logic [31:0] wd, input logic [3:0] ws);
        for (int i = 0; i < 4; i++)
            if (ws[i] && wa == PERF_OFS) mdl[i] = wd[8*i+:8] & msk[i];
        if (ws[0] && wa == DTC1_OFS) mdl[4] = wd[7:0] & DTC1_MASK;
    endtask : mdlWrite

    task automatic chkOut();
        logic [7:0] p, c1, c2, l, t;
        p = mdl[0];
        c1 = mdl[1];
        c2 = mdl[2];
        l = mdl[3];
        t = mdl[4];
        chk(extraTagBitOutput, p[7:6] != 2'h0);
        chk(rowStrobeAsTag, {p[7:6] == 2'h3, p[7]});
        chk(fastNextAddress, p[5]);
        chk(snoopSampleClock, p[4] ? 2 : 3);
        chk(hitCheckClock, p[0] ? 2 : 3);
        chk(cacheBanks, c1[7] ? 1 : 2);
        chk(pipelinedSram, c1[6]);
        chk(coherenceTestMode, c1[4]);
        chk(cacheSize, c1[2:1]);
        chk(cacheableLimitLog2, 26 + p[7:6]);
        chk(tagHoldHalfClock, c2[7]);
        chk(singleReadAllocate, c2[6]);
        chk(abRegionCacheable, c2[5] & abRegionLocal);
        chk(lookupDirty, !c2[4] && (c2[1] || tagDirty));
        chk(lookupHit, !c2[2] && tagHit && c2[0] && c1[2:1] != 2'h0);
        chk(l2Enable, c2[0]);
        chk(rowHalfWidth, l[7:2]);
        chk(readAroundWrite, l[1]);
        chk(cacheAllowN, !(l[0] && cacheableCycle));
        chk(edoDetectEnable, t[5]);
        chk(edoTimerClocks, 128 << t[7:6]);
        chk(rasToCasClocks, t[3] ? 2 : 3);
        chk(prechargeClocks, t[2] ? 3 : 4);
        chk(refreshRasClocks, t[2] ? 4 : 5);
        chk(edoReadClocks, t[4] ? 2 : 3);
        chk(pageReadClocks, t[1] ? 3 : 4);
        chk(writeClocks, t[0] ? 2 : 3);
    endtask : chkOut

    task automatic doReset();
        @(posedge ref_clk);
        rstn <= 1'b0;
        hostAddressStrap <= 4'($random(seed));
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge ref_clk);
        mdl = '{PERF_RST, 8'h00, CFG2_RST, L1DB_RST, DTC1_RST};
        mdl[1] = {hostAddressStrap[24:23], 3'b001, hostAddressStrap[22:21], 1'b0};
        axiRead(PERF_OFS, rd);
        chk(rd, word(PERF_OFS));
        axiRead(DTC1_OFS, rd);
        chk(rd, word(DTC1_OFS));
        chkOut();
    endtask : doReset

    initial begin
        seed = 32'h836D;
        ref_clk = 1'b0;
        rstn = 1'b0;
        hostAddressStrap = 4'h0;
        {abRegionLocal, cacheableCycle, tagHit, tagDirty} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        msk = '{PERF_MASK, CFG1_MASK, CFG2_MASK, L1DB_MASK, DTC1_MASK};
        doReset();
        for (int k = 0; k < 60; k++) begin
            a = (k % 7 == 6) ? 8'h48 : ($random(seed) & 1) ? PERF_OFS : DTC1_OFS;
            d = (k < 2) ? 32'hFFFFFFFF : $random(seed);
            s = (k < 2) ? 4'hF : 4'($random(seed));
            d[12] = 1'b0;
            d[11:8] = {1'b1, d[10:9], 1'b0};
            {abRegionLocal, cacheableCycle, tagHit, tagDirty} <= 4'($random(seed));
            axiWrite(a, d, s);
            mdlWrite(a, d, s);
            axiRead(a, rd);
            chk(rd, word(a));
            chkOut();
        end
        // reset again at the end of the run: straps reload, registers return to defaults
        doReset();
        final_report();
    end

    // whole run is well under a thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        final_report();
    end
endmodule : tb_top
